/* apc_pkg.sv */
// package: register map, field layout and encodings of the config bank
`default_nettype none
package apc_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] MEAS_CFG_IDX = 8'h12;
	localparam logic [7:0] PWM_CFG_IDX = 8'h13;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] MEAS_CFG_ADDR = ADDR_W'({MEAS_CFG_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] PWM_CFG_ADDR = ADDR_W'({PWM_CFG_IDX, 2'b00});
	localparam logic [15:0] MEAS_CFG_RESET = 16'h0000;
	localparam logic [15:0] PWM_CFG_RESET = 16'h0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
	// ------------------------------------------------------------
	// measurement config fields
	// ------------------------------------------------------------
	localparam int OD_REQ_BIT = 0;
	localparam int OD_SEL_LSB = 1;
	localparam int OD_FILT_BIT = 3;
	localparam int GEN_FILT_LSB = 4;
	localparam int SUP_FILT_LSB = 6;
	localparam int MEAS_USED_W = 8;
	// ------------------------------------------------------------
	// pwm config fields
	// ------------------------------------------------------------
	localparam int MODE_LSB = 0;
	localparam int FREEW_BIT = 3;
	localparam int BRAKE_LSB = 4;
	localparam int RECIRC_BIT = 6;
	localparam int PWM_USED_W = 7;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_DIGITAL_CURRENT = 2'h0;
	localparam logic [1:0] SEL_LOGIC_RAIL = 2'h1;
	localparam logic [1:0] SEL_BUCK_RAIL = 2'h2;
	localparam logic [2:0] MODE_SIX = 3'h0;
	localparam logic [2:0] MODE_THREE = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_SINGLE_HALL = 3'h3;
	localparam logic [1:0] BRAKE_LOW = 2'h0;
	localparam logic [1:0] BRAKE_HIGH = 2'h1;
	localparam logic [1:0] BRAKE_HIZ = 2'h2;
	localparam logic [1:0] BRAKE_TOGGLE = 2'h3;
	localparam logic [6:0] GEN_DEPTH_BASE = 7'h08;
	localparam logic [6:0] SUP_DEPTH_BASE = 7'h20;
endpackage : apc_pkg
`default_nettype wire

/* apc_depth_dec.sv */
// module: moving-average depth decoder for both filter fields
`timescale 1ns/1ps
`default_nettype none
module apc_depth_dec (
	input wire logic [1:0] gen_code,
	input wire logic [1:0] sup_code,
	output logic [6:0] gen_depth,
	output logic [6:0] sup_depth
);
	// general: 8 << code gives 8/16/32/64
	assign gen_depth = apc_pkg::GEN_DEPTH_BASE << gen_code;
	// supply: 32 >> code gives 32/16/8, code 3 means single sample
	assign sup_depth = (sup_code == 2'h3) ? 7'h01 :
		(apc_pkg::SUP_DEPTH_BASE >> sup_code);
endmodule : apc_depth_dec
`default_nettype wire

/* apc_brake_alt.sv */
// module: brake side selector with alternation on each braking event
`timescale 1ns/1ps
`default_nettype none
module apc_brake_alt (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] scheme,
	input wire logic brake_event,
	output logic high_side,
	output logic hiz
);
	logic last_high_q;
	logic pick_high;
	// toggle scheme starts from the side not used last
	always_comb begin
		case (scheme)
			apc_pkg::BRAKE_LOW: pick_high = 1'b0;
			apc_pkg::BRAKE_HIGH: pick_high = 1'b1;
			apc_pkg::BRAKE_TOGGLE: pick_high = ~last_high_q;
			// only high-z lands here: it drives neither side
			default: pick_high = 1'b0;
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			last_high_q <= 1'b0;
		end else if (brake_event && scheme != apc_pkg::BRAKE_HIZ) begin
			last_high_q <= pick_high;
		end
	end
	// fixed schemes show their side at once; toggle shows the last side
	assign high_side = (scheme == apc_pkg::BRAKE_TOGGLE && !brake_event) ?
		last_high_q : pick_high;
	assign hiz = (scheme == apc_pkg::BRAKE_HIZ);
endmodule : apc_brake_alt
`default_nettype wire

/* apc_cfg_regs.sv */
// module: measurement and pwm configuration registers on avalon-mm
//
// Summary of operation
// - a write with byte lane 0 enabled reloads every measurement field
// - request bit pulses one extra conversion
// - input select: current, logic rail, buck
// - filter enable pulses on, reads zero
// - general depth 8, 16, 32, 64
// - supply depth 32, 16, 8, 1
// - reserved upper bits read zero
// - mode: six, three, single input pwm
// - freewheel: active 0, diode 1
// - brake low, high or high-z
// - toggle brake alternates each event
// - recirc bit enables alternating recirculation
// - recirc ignored unless mode 011
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module apc_cfg_regs (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [apc_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic BRAKE_EVENT,
	output logic OD_CONV_REQUEST,
	output logic [1:0] OD_INPUT_SELECT,
	output logic OD_FILTER_ENABLE,
	output logic [6:0] GENERAL_FILTER_DEPTH,
	output logic [6:0] SUPPLY_FILTER_DEPTH,
	output logic [2:0] PWM_MODE,
	output logic FREEWHEEL_DIODE,
	output logic BRAKE_HIGH_SIDE,
	output logic BRAKE_HIZ,
	output logic ALT_RECIRC_ACTIVE
);
	// ------------------------------------------------------------
	// bus handshake: one wait cycle, answer on the second edge
	// ------------------------------------------------------------
	logic ack_q;
	logic [1:0] sel_q;
	logic [1:0] mode_sel_q;
	logic od_filt_q;
	logic [1:0] gen_q;
	logic [1:0] sup_q;
	logic [2:0] mode_q;
	logic freew_q;
	logic [1:0] brake_q;
	logic recirc_q;
	logic req_q;
	logic filt_q;
	logic [6:0] gen_depth_q;
	logic [6:0] sup_depth_q;
	logic brk_hi_q;
	logic brk_hiz_q;
	logic recirc_act_q;
	logic [31:0] rdata_q;
	logic wait_q;
	logic access;
	logic wr_meas;
	logic wr_pwm;
	logic [6:0] gen_depth;
	logic [6:0] sup_depth;
	logic brk_hi;
	logic brk_hiz;

	assign access = (AVS_READ | AVS_WRITE) & ~ack_q;
	// a write takes effect only at the edge where waitrequest is low
	assign wr_meas = AVS_WRITE & ack_q & AVS_BYTEENABLE[0] &
		(AVS_ADDRESS == apc_pkg::MEAS_CFG_ADDR);
	assign wr_pwm = AVS_WRITE & ack_q & AVS_BYTEENABLE[0] &
		(AVS_ADDRESS == apc_pkg::PWM_CFG_ADDR);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_q <= 1'b0;
			wait_q <= 1'b1;
		end else begin
			ack_q <= access;
			wait_q <= ~access;
		end
	end
	assign AVS_WAITREQUEST = wait_q;
	assign AVS_READDATA = rdata_q;

	// ------------------------------------------------------------
	// measurement config storage
	// ------------------------------------------------------------
	// whole-word load: a partial field write clears the others
	// (software is expected to read-modify-write)
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sel_q <= apc_pkg::MEAS_CFG_RESET[2:1];
			gen_q <= apc_pkg::MEAS_CFG_RESET[5:4];
			sup_q <= apc_pkg::MEAS_CFG_RESET[7:6];
		end else if (wr_meas) begin
			sel_q <= AVS_WRITEDATA[apc_pkg::OD_SEL_LSB +: 2];
			gen_q <= AVS_WRITEDATA[apc_pkg::GEN_FILT_LSB +: 2];
			sup_q <= AVS_WRITEDATA[apc_pkg::SUP_FILT_LSB +: 2];
		end
	end

	// code 11 is reserved; the last legal selection is kept for it
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_sel_q <= apc_pkg::SEL_DIGITAL_CURRENT;
		end else if (sel_q != 2'h3) begin
			mode_sel_q <= sel_q;
		end
	end

	// strobes: one-cycle pulses, never readable
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			req_q <= 1'b0;
			filt_q <= 1'b0;
		end else begin
			req_q <= wr_meas & AVS_WRITEDATA[apc_pkg::OD_REQ_BIT];
			filt_q <= wr_meas & AVS_WRITEDATA[apc_pkg::OD_FILT_BIT];
		end
	end
	assign od_filt_q = filt_q;

	// ------------------------------------------------------------
	// pwm config storage
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_q <= apc_pkg::PWM_CFG_RESET[2:0];
			freew_q <= apc_pkg::PWM_CFG_RESET[3];
			brake_q <= apc_pkg::PWM_CFG_RESET[5:4];
			recirc_q <= apc_pkg::PWM_CFG_RESET[6];
		end else if (wr_pwm) begin
			mode_q <= AVS_WRITEDATA[apc_pkg::MODE_LSB +: 3];
			freew_q <= AVS_WRITEDATA[apc_pkg::FREEW_BIT];
			brake_q <= AVS_WRITEDATA[apc_pkg::BRAKE_LSB +: 2];
			recirc_q <= AVS_WRITEDATA[apc_pkg::RECIRC_BIT];
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// strobe bits and reserved bits always return zero
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= apc_pkg::UNMAPPED_READ;
		end else if (access && AVS_READ) begin
			if (AVS_ADDRESS == apc_pkg::MEAS_CFG_ADDR) begin
				rdata_q <= {24'h000000, sup_q, gen_q, 1'b0, sel_q, 1'b0};
			end else if (AVS_ADDRESS == apc_pkg::PWM_CFG_ADDR) begin
				rdata_q <= {25'h0000000, recirc_q, brake_q, freew_q, mode_q};
			end else begin
				rdata_q <= apc_pkg::UNMAPPED_READ;
			end
		end
	end

	// ------------------------------------------------------------
	// decoded outputs
	// ------------------------------------------------------------
	apc_depth_dec u_depth (
		.gen_code(gen_q),
		.sup_code(sup_q),
		.gen_depth(gen_depth),
		.sup_depth(sup_depth)
	);

	// brake event is a pin: two sync flops, then a third for the rising edge
	logic brk_s1_q;
	logic brk_s2_q;
	logic brk_s3_q;
	logic brk_rise;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			brk_s1_q <= 1'b0;
			brk_s2_q <= 1'b0;
			brk_s3_q <= 1'b0;
		end else begin
			brk_s1_q <= BRAKE_EVENT;
			brk_s2_q <= brk_s1_q;
			brk_s3_q <= brk_s2_q;
		end
	end
	assign brk_rise = brk_s2_q & ~brk_s3_q;

	apc_brake_alt u_brake (
		.clk(CLK),
		.resetn(RESETN),
		.scheme(brake_q),
		.brake_event(brk_rise),
		.high_side(brk_hi),
		.hiz(brk_hiz)
	);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			gen_depth_q <= apc_pkg::GEN_DEPTH_BASE;
			sup_depth_q <= apc_pkg::SUP_DEPTH_BASE;
			brk_hi_q <= 1'b0;
			brk_hiz_q <= 1'b0;
			recirc_act_q <= 1'b0;
		end else begin
			gen_depth_q <= gen_depth;
			sup_depth_q <= sup_depth;
			brk_hi_q <= brk_hi;
			brk_hiz_q <= brk_hiz;
			recirc_act_q <= recirc_q &
				(mode_q == apc_pkg::MODE_SINGLE_HALL);
		end
	end

	assign OD_CONV_REQUEST = req_q;
	assign OD_INPUT_SELECT = mode_sel_q;
	assign OD_FILTER_ENABLE = od_filt_q;
	assign GENERAL_FILTER_DEPTH = gen_depth_q;
	assign SUPPLY_FILTER_DEPTH = sup_depth_q;
	assign PWM_MODE = mode_q;
	assign FREEWHEEL_DIODE = freew_q;
	assign BRAKE_HIGH_SIDE = brk_hi_q;
	assign BRAKE_HIZ = brk_hiz_q;
	assign ALT_RECIRC_ACTIVE = recirc_act_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	req_pulse_a: assert property (
		wr_meas && AVS_WRITEDATA[0]
		|=> OD_CONV_REQUEST ##1 !OD_CONV_REQUEST)
		else $error("req pulse");
	filt_pulse_a: assert property (
		OD_FILTER_ENABLE |=> !OD_FILTER_ENABLE)
		else $error("filter enable not a pulse");
	full_load_a: assert property (
		wr_meas |=> gen_q == $past(AVS_WRITEDATA[5:4])
		&& sup_q == $past(AVS_WRITEDATA[7:6])
		&& sel_q == $past(AVS_WRITEDATA[2:1]))
		else $error("partial meas load");
	meas_rd_a: assert property (
		AVS_READ && !AVS_WAITREQUEST
		&& AVS_ADDRESS == apc_pkg::MEAS_CFG_ADDR
		|-> AVS_READDATA[31:8] == 24'h000000 && !AVS_READDATA[0]
		&& !AVS_READDATA[3])
		else $error("meas read bits");
	pwm_rd_a: assert property (
		AVS_READ && !AVS_WAITREQUEST
		&& AVS_ADDRESS == apc_pkg::PWM_CFG_ADDR
		|-> AVS_READDATA[31:7] == 25'h0000000)
		else $error("pwm reserved");
	gen_depth_a: assert property (
		(gen_q == 2'h3) [*2] |-> GENERAL_FILTER_DEPTH == 7'h40)
		else $error("general depth");
	sup_depth_a: assert property (
		(sup_q == 2'h3) [*2] |-> SUPPLY_FILTER_DEPTH == 7'h01)
		else $error("supply depth");
	// the reserved select must never reach the sequencer
	sel_hold_a: assert property (
		sel_q == 2'h3 |=> OD_INPUT_SELECT == $past(OD_INPUT_SELECT))
		else $error("reserved select taken");
	sel_load_a: assert property (
		sel_q != 2'h3 |=> OD_INPUT_SELECT == $past(sel_q))
		else $error("select not followed");
	recirc_gate_a: assert property (
		mode_q != apc_pkg::MODE_SINGLE_HALL |=> !ALT_RECIRC_ACTIVE)
		else $error("recirc outside mode");
	mode_load_a: assert property (
		wr_pwm |=> PWM_MODE == $past(AVS_WRITEDATA[2:0])
		&& FREEWHEEL_DIODE == $past(AVS_WRITEDATA[3]))
		else $error("pwm load");
	brake_high_a: assert property (
		(brake_q == apc_pkg::BRAKE_HIGH) [*2]
		|-> BRAKE_HIGH_SIDE && !BRAKE_HIZ)
		else $error("fixed high side");
	brake_low_a: assert property (
		(brake_q == apc_pkg::BRAKE_LOW) [*2]
		|-> !BRAKE_HIGH_SIDE && !BRAKE_HIZ)
		else $error("fixed low side");
	brake_hiz_a: assert property (
		brake_q == apc_pkg::BRAKE_HIZ |=> BRAKE_HIZ && !BRAKE_HIGH_SIDE)
		else $error("high-z brake");
	brake_alt_a: assert property (
		brk_rise && brake_q == apc_pkg::BRAKE_TOGGLE
		|-> brk_hi != u_brake.last_high_q)
		else $error("no alternation");
	wait_bound_a: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("wait too long");
	// a held request must not be answered twice
	ack_once_a: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer longer than one cycle");

	cov_req_c: cover property (OD_CONV_REQUEST);
	cov_filt_c: cover property (OD_FILTER_ENABLE);
	cov_sel_hold_c: cover property (sel_q == 2'h3);
	cov_toggle_c: cover property (brk_rise && brake_q == apc_pkg::BRAKE_TOGGLE);
	cov_recirc_c: cover property (ALT_RECIRC_ACTIVE);
endmodule : apc_cfg_regs
`default_nettype wire

/* apc_cfg_regs_tb.sv */
// testbench: bus access, field decode and brake checks of the config bank
`timescale 1ns/1ps
`default_nettype none
module apc_cfg_regs_tb;
	// ------------------------------------------------------------
	// stimulus and design
	// ------------------------------------------------------------
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [apc_pkg::ADDR_W-1:0] AVS_ADDRESS = '0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic BRAKE_EVENT = 1'b0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST, OD_CONV_REQUEST, OD_FILTER_ENABLE, FREEWHEEL_DIODE;
	logic [1:0] OD_INPUT_SELECT;
	logic [6:0] GENERAL_FILTER_DEPTH, SUPPLY_FILTER_DEPTH;
	logic [2:0] PWM_MODE;
	logic BRAKE_HIGH_SIDE, BRAKE_HIZ, ALT_RECIRC_ACTIVE;
	int error_cnt = 0;
	int total_checks = 0;
	logic [31:0] rnd = 32'h0A844399;
	always #10 CLK = ~CLK;
	apc_cfg_regs dut (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.BRAKE_EVENT(BRAKE_EVENT), .OD_CONV_REQUEST(OD_CONV_REQUEST),
		.OD_INPUT_SELECT(OD_INPUT_SELECT), .OD_FILTER_ENABLE(OD_FILTER_ENABLE),
		.GENERAL_FILTER_DEPTH(GENERAL_FILTER_DEPTH),
		.SUPPLY_FILTER_DEPTH(SUPPLY_FILTER_DEPTH), .PWM_MODE(PWM_MODE),
		.FREEWHEEL_DIODE(FREEWHEEL_DIODE), .BRAKE_HIGH_SIDE(BRAKE_HIGH_SIDE),
		.BRAKE_HIZ(BRAKE_HIZ), .ALT_RECIRC_ACTIVE(ALT_RECIRC_ACTIVE));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [6:0] gen_exp(input logic [1:0] c);
		return 7'h08 << c;
	endfunction : gen_exp
	// code 3 means no averaging, so it breaks the halving pattern
	function automatic logic [6:0] sup_exp(input logic [1:0] c);
		return (c == 2'h3) ? 7'h01 : (7'h20 >> c);
	endfunction : sup_exp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// holds the request until waitrequest is sampled low, bounded
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			$display("MISMATCH t=%0t bus timeout", $time);
			close_out();
		end
	endtask : bus
	task automatic settle();
		repeat (3) @(posedge CLK);
		#1;
	endtask : settle
	// one braking event on the pin, then time for sync and output flop
	task automatic brake_pulse();
		@(posedge CLK);
		BRAKE_EVENT <= 1'b1;
		repeat (3) @(posedge CLK);
		BRAKE_EVENT <= 1'b0;
		repeat (6) @(posedge CLK);
		#1;
	endtask : brake_pulse
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q, d;
		logic [1:0] sel;
		repeat (5) @(posedge CLK);
		RESETN <= 1'b1;
		#1;
		chk(GENERAL_FILTER_DEPTH, 32'h8, "gen reset");
		chk(SUPPLY_FILTER_DEPTH, 32'h20, "sup reset");
		bus(1'b0, apc_pkg::MEAS_CFG_ADDR, 32'h0, 4'hF, q);
		chk(q, 32'h0, "meas reset");
		bus(1'b0, apc_pkg::PWM_CFG_ADDR, 32'h0, 4'hF, q);
		chk(q, 32'h0, "pwm reset");
		$display("test reset done");
		// toggle scheme first, so no earlier event has used a side
		bus(1'b1, apc_pkg::PWM_CFG_ADDR, 32'h30, 4'hF, q);
		for (int i = 0; i < 4; i++) begin
			brake_pulse();
			chk(BRAKE_HIGH_SIDE, {31'h0, ~i[0]}, "toggle side");
			chk(BRAKE_HIZ, 32'h0, "toggle hiz");
		end
		$display("test brake toggle done");
		// modes restricted to codes 0 to 2, so not mode 011, recirc random
		for (int i = 0; i < 18; i++) begin
			rnd = lfsr(rnd);
			d = {rnd[31:7], rnd[6], 2'(i % 3), 1'(i / 9), 3'(i / 3 % 3)};
			bus(1'b1, apc_pkg::PWM_CFG_ADDR, d, 4'hF, q);
			settle();
			chk(PWM_MODE, d[2:0], "mode");
			chk(FREEWHEEL_DIODE, d[3], "freewheel");
			chk(BRAKE_HIGH_SIDE, d[5:4] == 2'h1, "brake high");
			chk(BRAKE_HIZ, d[5:4] == 2'h2, "brake hiz");
			chk(ALT_RECIRC_ACTIVE, 32'h0, "recirc");
			bus(1'b0, apc_pkg::PWM_CFG_ADDR, 32'h0, 4'hF, q);
			chk(q, {25'h0, d[6:0]}, "pwm read");
		end
		$display("test pwm fields done");
		// a fixed-side event sets the side that toggling avoids next
		bus(1'b1, apc_pkg::PWM_CFG_ADDR, 32'h10, 4'hF, q);
		brake_pulse();
		chk(BRAKE_HIGH_SIDE, 32'h1, "fixed high");
		bus(1'b1, apc_pkg::PWM_CFG_ADDR, 32'h30, 4'hF, q);
		brake_pulse();
		chk(BRAKE_HIGH_SIDE, 32'h0, "toggle after high");
		$display("test brake history done");
		sel = 2'h0;
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h2 : rnd;
			bus(1'b1, apc_pkg::MEAS_CFG_ADDR, d, 4'hF, q);
			#1;
			chk(OD_CONV_REQUEST, d[0], "req pulse");
			chk(OD_FILTER_ENABLE, d[3], "filt pulse");
			@(posedge CLK);
			#1;
			chk({OD_CONV_REQUEST, OD_FILTER_ENABLE}, 32'h0, "pulse end");
			if (d[2:1] != 2'h3) begin
				sel = d[2:1];
			end
			settle();
			chk(OD_INPUT_SELECT, sel, "select");
			chk(GENERAL_FILTER_DEPTH, gen_exp(d[5:4]), "gen depth");
			chk(SUPPLY_FILTER_DEPTH, sup_exp(d[7:6]), "sup depth");
			bus(1'b0, apc_pkg::MEAS_CFG_ADDR, 32'h0, 4'hF, q);
			chk(q, d & 32'hF6, "meas read");
		end
		$display("test meas fields done");
		bus(1'b1, 10'h050, 32'hFF, 4'hF, q);
		bus(1'b0, 10'h050, 32'h0, 4'hF, q);
		chk(q, apc_pkg::UNMAPPED_READ, "unmapped");
		bus(1'b1, apc_pkg::MEAS_CFG_ADDR, 32'hF0, 4'hE, q);
		bus(1'b0, apc_pkg::MEAS_CFG_ADDR, 32'h0, 4'hF, q);
		chk(q, d & 32'hF6, "lane off");
		$display("test refusals done");
		close_out();
	end
endmodule : apc_cfg_regs_tb
`default_nettype wire
